// File: io_register_space_decoder.sv
// Lower 33 addresses (0x00 to 0x20) of the I/O register space: decode, storage and bit access for the core.
// Assumes the core, the peripheral logic and the flag events share CLOCK; pins are async.
//
// Notes on behaviour
// - Bit set and clear work on addresses 0x00 to 0x1F only.
// - In that range a single bit can be tested for skip-if-set or skip-if-clear.
// - Certain flags clear on writing one; writing zero leaves them.
// - A bit operation changes only its addressed bit, no other flags.
// - Direct reads and writes decode addresses 0x00 through 0x3F.
// - Data-space loads and stores reach each register at its I/O address plus 0x20.
`timescale 1ns/1ps
module io_register_space_decoder
   import io_space_pkg::*;
#(
   parameter int NWORDS = BANK_WORDS
) (
   // Clock and reset
   input  wire logic                CLOCK,
   input  wire logic                RST,
   // Core request and answer
   input  wire core_req_t           CORE_REQ,
   output logic [7:0]               CORE_RDATA,
   output logic                     CORE_SKIP,
   output logic                     CORE_DONE,
   output logic                     CORE_REFUSED,
   // Port pins, asynchronous
   input  wire logic [2:0]          PIN_A,
   input  wire logic [7:0]          PIN_B,
   input  wire logic [6:0]          PIN_D,
   // Peripheral status levels and flag events
   input  wire status_lvl_t         STATUS_LVL,
   input  wire flag_evt_t           FLAG_EVT,
   // Register image and write strobes toward the peripherals
   output logic [NWORDS*8-1:0]      REG_IMAGE,
   output logic [NWORDS-1:0]        WRITE_STROBE
);

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic [17:0] pin_meta_r;
   logic [17:0] pin_sync_r;

   always_ff @(posedge CLOCK) begin
      pin_meta_r <= {PIN_D, PIN_B, PIN_A};
      pin_sync_r <= pin_meta_r;
   end

   wire logic [2:0] pin_a_s;
   wire logic [7:0] pin_b_s;
   wire logic [6:0] pin_d_s;

   assign pin_a_s = pin_sync_r[2:0];
   assign pin_b_s = pin_sync_r[10:3];
   assign pin_d_s = pin_sync_r[17:11];

   // ----------------------------------------------------------------------
   // Live levels and flag events, per address
   // ----------------------------------------------------------------------
   function automatic logic [7:0] hw_value(input logic [5:0] a,
                                           input logic [2:0] pa,
                                           input logic [7:0] pb,
                                           input logic [6:0] pd,
                                           input status_lvl_t s);
      logic [7:0] v;
      v = 8'h00;
      if (a == ADDR_PORT_A_INPUT) begin
         v = {5'h00, pa};
      end else if (a == ADDR_PORT_B_INPUT) begin
         v = pb;
      end else if (a == ADDR_PORT_D_INPUT) begin
         v = {1'b0, pd};
      end else if (a == ADDR_COMPARATOR_CTRL_STAT) begin
         v = {2'b00, s.comp_out, 5'h00};
      end else if (a == ADDR_SERIAL_STATUS_A) begin
         v = {s.rx_complete, 1'b0, s.data_empty, s.frame_err, s.overrun, s.parity_err, 2'b00};
      end else if (a == ADDR_UNIV_SERIAL_STATUS) begin
         v = {3'b000, s.usi_collision, 4'h0};
      end
      return v;
   endfunction

   function automatic logic [7:0] flag_value(input logic [5:0] a, input flag_evt_t e);
      logic [7:0] v;
      v = 8'h00;
      if (a == ADDR_COMPARATOR_CTRL_STAT) begin
         v = {3'b000, e.comp_int, 4'h0};
      end else if (a == ADDR_SERIAL_STATUS_A) begin
         v = {1'b0, e.tx_complete, 6'h00};
      end else if (a == ADDR_UNIV_SERIAL_STATUS) begin
         v = {e.usi_start, e.usi_overflow, e.usi_stop, 5'h00};
      end
      return v;
   endfunction

   // ----------------------------------------------------------------------
   // Request decode
   // ----------------------------------------------------------------------
   wire logic       is_ds;
   wire logic       is_bit;
   wire logic       is_test;
   wire logic       is_write;
   wire logic       is_set;
   wire logic       is_clear;
   wire logic [7:0] io_addr;
   wire logic       addr_ok;
   wire logic       taken;
   wire logic       in_bank;
   wire logic [5:0] word;

   assign is_ds    = (CORE_REQ.op == DATA_SPACE_LOAD_OP) ||
                     (CORE_REQ.op == DATA_SPACE_STORE_OP);
   assign is_set   = (CORE_REQ.op == SET_IO_BIT_OP);
   assign is_clear = (CORE_REQ.op == CLEAR_IO_BIT_OP);
   assign is_test  = (CORE_REQ.op == SKIP_IF_IO_BIT_SET_OP) ||
                     (CORE_REQ.op == SKIP_IF_IO_BIT_CLEAR_OP);
   assign is_bit   = is_set || is_clear || is_test;
   assign is_write = (CORE_REQ.op == IO_WRITE_OP) || (CORE_REQ.op == DATA_SPACE_STORE_OP);
   // Data space sits one offset above the direct I/O view.
   assign io_addr  = is_ds ? (CORE_REQ.addr - DS_OFFSET) : CORE_REQ.addr;
   // Direct access spans the whole I/O space, bit access only its low part.
   assign addr_ok  = is_ds  ? ((CORE_REQ.addr >= DS_OFFSET) && (io_addr <= IO_LAST)) :
                     is_bit ? (CORE_REQ.addr <= BIT_LAST) :
                              (CORE_REQ.addr <= IO_LAST);
   assign taken    = CORE_REQ.valid && addr_ok;
   assign in_bank  = io_addr <= BANK_LAST;
   assign word     = io_addr[5:0];

   // ----------------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------------
   logic [7:0] store_r [0:NWORDS-1];
   logic [7:0] read_val [0:NWORDS-1];
   logic [NWORDS-1:0] strobe_r;

   genvar g;
   generate
      for (g = 0; g < NWORDS; g++) begin : gen_word
         wire logic       hit;
         wire logic [7:0] store_mask;
         wire logic [7:0] hw_mask;
         wire logic [7:0] word_nxt;

         assign hit        = taken && in_bank && (word == 6'(g));
         // Reserved bits are never stored and so never change.
         assign store_mask = IMPL_MASK[g] & ~HW_MASK[g];
         assign hw_mask    = IMPL_MASK[g] & HW_MASK[g];

         io_bit_update u_update (
            .old_val    (store_r[g]),
            .store_mask (store_mask),
            .w1c_mask   (W1C_MASK[g]),
            .flag_set   (flag_value(6'(g), FLAG_EVT)),
            .do_write   (hit && is_write),
            .do_set     (hit && is_set),
            .do_clear   (hit && is_clear),
            .wdata      (CORE_REQ.wdata),
            .bitsel     (CORE_REQ.bitsel),
            .new_val    (word_nxt)
         );

         // Reserved bits read as zero.
         assign read_val[g] = (store_r[g] & store_mask) |
                              (hw_value(6'(g), pin_a_s, pin_b_s, pin_d_s, STATUS_LVL) & hw_mask);

         always_ff @(posedge CLOCK) begin
            if (RST) begin
               store_r[g]  <= RESET_VAL;
               strobe_r[g] <= 1'b0;
            end else begin
               store_r[g]  <= word_nxt;
               strobe_r[g] <= hit && (is_write || is_set || is_clear);
            end
         end

         assign REG_IMAGE[g*8 +: 8] = store_r[g];
      end
   endgenerate

   assign WRITE_STROBE = strobe_r;

   // ----------------------------------------------------------------------
   // Answer to the core
   // ----------------------------------------------------------------------
   // Upper I/O addresses belong to other banks; here they read zero.
   wire logic [7:0] rd_word;
   wire logic       test_bit;
   wire logic       skip_nxt;

   assign rd_word  = in_bank ? read_val[word] : 8'h00;
   // A single bit is tested without handing back the register.
   assign test_bit = rd_word[CORE_REQ.bitsel];
   assign skip_nxt = is_test && ((CORE_REQ.op == SKIP_IF_IO_BIT_SET_OP) ? test_bit : !test_bit);

   logic [7:0] rdata_r;
   logic       skip_r;
   logic       done_r;
   logic       refused_r;

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         rdata_r   <= RESET_VAL;
         skip_r    <= 1'b0;
         done_r    <= 1'b0;
         refused_r <= 1'b0;
      end else begin
         rdata_r   <= (taken && !is_bit && !is_write) ? rd_word : RESET_VAL;
         skip_r    <= taken && skip_nxt;
         done_r    <= taken;
         // Bit access above the low range is refused and changes nothing.
         refused_r <= CORE_REQ.valid && !addr_ok;
      end
   end

   assign CORE_RDATA   = rdata_r;
   assign CORE_SKIP    = skip_r;
   assign CORE_DONE    = done_r;
   assign CORE_REFUSED = refused_r;

endmodule

// File: io_space_pkg.sv
// Package for the lower I/O register space decoder: ops, carriers, addresses and bit masks.
// Assumes one system clock, with the core and the peripheral logic on that clock.
package io_space_pkg;

   // ----------------------------------------------------------------------
   // Address map
   // ----------------------------------------------------------------------
   localparam int          BANK_WORDS = 33;
   localparam logic [7:0]  IO_LAST    = 8'h3f;
   localparam logic [7:0]  BIT_LAST   = 8'h1f;
   localparam logic [7:0]  DS_OFFSET  = 8'h20;
   localparam logic [7:0]  BANK_LAST  = 8'h20;
   localparam logic [7:0]  RESET_VAL  = 8'h00;

   localparam logic [5:0]  ADDR_DIGITAL_INPUT_DISABLE = 6'h01;
   localparam logic [5:0]  ADDR_BAUD_DIVISOR_HIGH     = 6'h02;
   localparam logic [5:0]  ADDR_SERIAL_FRAME_FORMAT   = 6'h03;
   localparam logic [5:0]  ADDR_COMPARATOR_CTRL_STAT  = 6'h08;
   localparam logic [5:0]  ADDR_BAUD_DIVISOR_LOW      = 6'h09;
   localparam logic [5:0]  ADDR_SERIAL_CONTROL_B      = 6'h0a;
   localparam logic [5:0]  ADDR_SERIAL_STATUS_A       = 6'h0b;
   localparam logic [5:0]  ADDR_SERIAL_DATA_BUFFER    = 6'h0c;
   localparam logic [5:0]  ADDR_UNIV_SERIAL_CONTROL   = 6'h0d;
   localparam logic [5:0]  ADDR_UNIV_SERIAL_STATUS    = 6'h0e;
   localparam logic [5:0]  ADDR_UNIV_SERIAL_SHIFT     = 6'h0f;
   localparam logic [5:0]  ADDR_PORT_D_INPUT          = 6'h10;
   localparam logic [5:0]  ADDR_PORT_D_DIRECTION      = 6'h11;
   localparam logic [5:0]  ADDR_PORT_D_OUTPUT         = 6'h12;
   localparam logic [5:0]  ADDR_SCRATCH_REG_ZERO      = 6'h13;
   localparam logic [5:0]  ADDR_SCRATCH_REG_ONE       = 6'h14;
   localparam logic [5:0]  ADDR_SCRATCH_REG_TWO       = 6'h15;
   localparam logic [5:0]  ADDR_PORT_B_INPUT          = 6'h16;
   localparam logic [5:0]  ADDR_PORT_B_DIRECTION      = 6'h17;
   localparam logic [5:0]  ADDR_PORT_B_OUTPUT         = 6'h18;
   localparam logic [5:0]  ADDR_PORT_A_INPUT          = 6'h19;
   localparam logic [5:0]  ADDR_PORT_A_DIRECTION      = 6'h1a;
   localparam logic [5:0]  ADDR_PORT_A_OUTPUT         = 6'h1b;
   localparam logic [5:0]  ADDR_NVM_CONTROL           = 6'h1c;
   localparam logic [5:0]  ADDR_NVM_DATA              = 6'h1d;
   localparam logic [5:0]  ADDR_NVM_ADDRESS           = 6'h1e;
   localparam logic [5:0]  ADDR_PIN_CHANGE_MASK       = 6'h20;

   // ----------------------------------------------------------------------
   // Bit masks, indexed by I/O address
   // ----------------------------------------------------------------------
   // Implemented bits; everything else is reserved and reads zero.
   localparam logic [7:0] IMPL_MASK [0:BANK_WORDS-1] = '{
      8'h00, 8'h03, 8'h0f, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h00,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
      8'h7f, 8'h7f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
      8'hff, 8'h07, 8'h07, 8'h07, 8'h3f, 8'hff, 8'h7f, 8'h00,
      8'hff};
   // Status flags cleared by writing a one.
   localparam logic [7:0] W1C_MASK [0:BANK_WORDS-1] = '{
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h10, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'he0, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00};
   // Bits whose value is a live level from outside, never stored.
   localparam logic [7:0] HW_MASK [0:BANK_WORDS-1] = '{
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h20, 8'h00, 8'h00, 8'hbc, 8'h00, 8'h00, 8'h10, 8'h00,
      8'h7f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00,
      8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00};

   // ----------------------------------------------------------------------
   // Operations and carriers
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      IO_READ_OP              = 3'b000,
      IO_WRITE_OP             = 3'b001,
      SET_IO_BIT_OP           = 3'b010,
      CLEAR_IO_BIT_OP         = 3'b011,
      SKIP_IF_IO_BIT_SET_OP   = 3'b100,
      SKIP_IF_IO_BIT_CLEAR_OP = 3'b101,
      DATA_SPACE_LOAD_OP      = 3'b110,
      DATA_SPACE_STORE_OP     = 3'b111
   } core_op_t;

   typedef struct packed {
      logic       valid;
      core_op_t   op;
      logic [7:0] addr;
      logic [2:0] bitsel;
      logic [7:0] wdata;
   } core_req_t;

   typedef struct packed {
      logic       comp_out;
      logic       rx_complete;
      logic       data_empty;
      logic       frame_err;
      logic       overrun;
      logic       parity_err;
      logic       usi_collision;
   } status_lvl_t;

   typedef struct packed {
      logic       comp_int;
      logic       tx_complete;
      logic       usi_start;
      logic       usi_overflow;
      logic       usi_stop;
   } flag_evt_t;

endpackage

// File: io_bit_update.sv
// Next value of one register of the bank for a full write, a bit set or a bit clear.
// Assumes the caller asserts at most one of the three operation inputs in a cycle.
`timescale 1ns/1ps
module io_bit_update (
   // Current state and masks
   input  wire logic [7:0] old_val,
   input  wire logic [7:0] store_mask,
   input  wire logic [7:0] w1c_mask,
   input  wire logic [7:0] flag_set,
   // Operation
   input  wire logic       do_write,
   input  wire logic       do_set,
   input  wire logic       do_clear,
   input  wire logic [7:0] wdata,
   input  wire logic [2:0] bitsel,
   // Result
   output logic [7:0]      new_val
);
   wire logic [7:0] onehot;
   wire logic [7:0] plain;
   wire logic [7:0] plain_nxt;
   wire logic [7:0] clr;

   assign onehot    = 8'h01 << bitsel;
   assign plain     = store_mask & ~w1c_mask;
   // A bit operation touches only the addressed position.
   assign plain_nxt = do_write ? wdata :
                      do_set   ? (old_val | onehot) :
                      do_clear ? (old_val & ~onehot) : old_val;
   // A one clears a flag and a zero leaves it.
   assign clr       = do_write ? (wdata & w1c_mask) :
                      do_set   ? (onehot & w1c_mask) : 8'h00;
   // A flag raised in the clearing cycle survives the clear.
   assign new_val   = (plain_nxt & plain) | (((old_val & ~clr) | flag_set) & w1c_mask);
endmodule

// File: periph_model.sv
// Far-side model: pin levels, status levels and one-cycle flag events.
// Assumes it shares CLOCK with the decoder; the bench drives its requests.
`timescale 1ns/1ps
module periph_model
   import io_space_pkg::*;
(
   // Clock
   input  wire logic        CLOCK,
   // Requests from the bench
   input  wire flag_evt_t   evt_req,
   input  wire logic [7:0]  pin_lvl,
   input  wire status_lvl_t lvl_req,
   // Toward the decoder
   output logic [2:0]       pin_a,
   output logic [7:0]       pin_b,
   output logic [6:0]       pin_d,
   output status_lvl_t      lvl,
   output flag_evt_t        evt
);
   flag_evt_t evt_last_r;
   // A held request raises one pulse only, as a real flag source would.
   always_ff @(posedge CLOCK) begin
      evt_last_r <= evt_req;
      evt        <= evt_req & ~evt_last_r;
   end
   assign pin_a = pin_lvl[2:0];
   assign pin_b = pin_lvl;
   assign pin_d = pin_lvl[6:0];
   assign lvl   = lvl_req;
endmodule

// File: io_space_assertions.sv
// Checker for the lower I/O register space decoder, on its ports only.
// Assumes one clock and a synchronous active-high reset; bound at the foot.
`timescale 1ns/1ps
module io_space_assertions
   import io_space_pkg::*;
#(
   parameter int NWORDS = BANK_WORDS
) (
   // Clock and reset
   input wire logic                CLOCK,
   input wire logic                RST,
   // Core side
   input wire core_req_t           CORE_REQ,
   input wire logic [7:0]          CORE_RDATA,
   input wire logic                CORE_SKIP,
   input wire logic                CORE_DONE,
   input wire logic                CORE_REFUSED,
   // Peripheral side
   input wire flag_evt_t           FLAG_EVT,
   input wire logic [NWORDS*8-1:0] REG_IMAGE,
   input wire logic [NWORDS-1:0]   WRITE_STROBE
);
   logic [5:0] sel_idx;
   logic [5:0] ds_idx;
   logic [7:0] cur_byte;
   logic [7:0] bit_one;
   logic       cur_bit;
   logic       in_scratch;
   logic       wr;
   assign sel_idx    = CORE_REQ.addr[5:0];
   assign ds_idx     = 6'(CORE_REQ.addr - DS_OFFSET);
   assign cur_byte   = REG_IMAGE[sel_idx*8 +: 8];
   assign bit_one    = 8'h01 << CORE_REQ.bitsel;
   assign cur_bit    = cur_byte[CORE_REQ.bitsel];
   assign in_scratch = CORE_REQ.addr inside {[8'h13:8'h15]};
   assign wr         = CORE_REQ.valid && CORE_REQ.op == IO_WRITE_OP;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);
   sequence scratch_req(core_op_t o);
      CORE_REQ.valid && CORE_REQ.op == o && in_scratch;
   endsequence
   sequence skip_req;
      CORE_REQ.valid && in_scratch && CORE_REQ.op[2:1] == 2'b10;
   endsequence
   bit_refuse_a: assert property (CORE_REQ.valid && CORE_REQ.addr > BIT_LAST &&
      CORE_REQ.op inside {[SET_IO_BIT_OP:SKIP_IF_IO_BIT_CLEAR_OP]} |=> CORE_REFUSED && !CORE_DONE)
      else $error("bit op beyond bit range not refused");
   direct_refuse_a: assert property (CORE_REQ.valid && CORE_REQ.addr > IO_LAST &&
      CORE_REQ.op inside {IO_READ_OP, IO_WRITE_OP} |=> CORE_REFUSED && !CORE_DONE)
      else $error("direct access beyond range not refused");
   store_map_a: assert property (CORE_REQ.valid && CORE_REQ.op == DATA_SPACE_STORE_OP &&
      CORE_REQ.addr inside {[8'h20:8'h40]} |=> WRITE_STROBE[$past(ds_idx)] && CORE_DONE)
      else $error("store not mapped at offset");
   ds_refuse_a: assert property (CORE_REQ.valid && CORE_REQ.op inside {DATA_SPACE_LOAD_OP,
      DATA_SPACE_STORE_OP} && (CORE_REQ.addr < DS_OFFSET || CORE_REQ.addr > 8'h5f)
      |=> CORE_REFUSED && !CORE_DONE)
      else $error("data-space access beyond range not refused");
   set_bit_a: assert property (scratch_req(SET_IO_BIT_OP) |=>
      REG_IMAGE[$past(sel_idx)*8 +: 8] == ($past(cur_byte) | $past(bit_one)))
      else $error("bit set changed more than its bit");
   skip_bit_a: assert property (skip_req |=> CORE_DONE && CORE_RDATA == 8'h00 &&
      CORE_SKIP == ($past(cur_bit) ^ ($past(CORE_REQ.op) == SKIP_IF_IO_BIT_CLEAR_OP)))
      else $error("skip answer wrong");
   w1c_clear_a: assert property (wr && CORE_REQ.addr == 8'h0e && CORE_REQ.wdata[7] &&
      FLAG_EVT == '0 |=> !REG_IMAGE[8'h0e*8+7])
      else $error("flag not cleared by writing one");
   reserved_loc_a: assert property (wr && CORE_REQ.addr inside {[8'h04:8'h07]} |=>
      CORE_DONE && REG_IMAGE[$past(sel_idx)*8 +: 8] == 8'h00)
      else $error("reserved location took a write");
   idle_quiet_a: assert property (!CORE_REQ.valid |=>
      !CORE_DONE && !CORE_REFUSED && WRITE_STROBE == '0)
      else $error("answer without request");
endmodule
bind io_register_space_decoder io_space_assertions #(.NWORDS(NWORDS)) checker_i (
   .CLOCK(CLOCK), .RST(RST), .CORE_REQ(CORE_REQ), .CORE_RDATA(CORE_RDATA),
   .CORE_SKIP(CORE_SKIP), .CORE_DONE(CORE_DONE), .CORE_REFUSED(CORE_REFUSED),
   .FLAG_EVT(FLAG_EVT), .REG_IMAGE(REG_IMAGE), .WRITE_STROBE(WRITE_STROBE));

// File: io_register_space_decoder_bench.sv
// Self-checking bench for the lower I/O register space decoder.
// Assumes the far-side model beside the decoder and the bound checker.
`timescale 1ns/1ps
module io_register_space_decoder_bench;
   import io_space_pkg::*;
   logic                    clk = 1'b0;
   logic                    rst = 1'b1;
   core_req_t               req = '0;
   flag_evt_t               evt_req = '0;
   status_lvl_t             lvl_req = '0;
   logic [7:0]              pin_lvl = 8'h00;
   logic [7:0]              rdata;
   logic                    skip;
   logic                    done;
   logic                    refused;
   logic [2:0]              pa;
   logic [7:0]              pb;
   logic [6:0]              pd;
   status_lvl_t             lvl;
   flag_evt_t               evt;
   logic [BANK_WORDS*8-1:0] image;
   logic [BANK_WORDS-1:0]   strobe;
   int                      errors = 0;
   int                      checks = 0;
   always #4 clk = ~clk;
   io_register_space_decoder dut (
      .CLOCK(clk), .RST(rst), .CORE_REQ(req), .CORE_RDATA(rdata), .CORE_SKIP(skip),
      .CORE_DONE(done), .CORE_REFUSED(refused), .PIN_A(pa), .PIN_B(pb), .PIN_D(pd),
      .STATUS_LVL(lvl), .FLAG_EVT(evt), .REG_IMAGE(image), .WRITE_STROBE(strobe));
   periph_model pm (
      .CLOCK(clk), .evt_req(evt_req), .pin_lvl(pin_lvl), .lvl_req(lvl_req),
      .pin_a(pa), .pin_b(pb), .pin_d(pd), .lvl(lvl), .evt(evt));
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   function automatic logic [7:0] byte_at(input int a);
      return image[a*8 +: 8];
   endfunction
   // Answers are sampled just after the edge that launches them.
   task automatic go(input core_op_t op, input logic [7:0] a, input logic [2:0] b,
                     input logic [7:0] d);
      @(posedge clk);
      req <= '{1'b1, op, a, b, d};
      @(posedge clk);
      req.valid <= 1'b0;
      #1;
   endtask
   task automatic t_map;
      logic [7:0] e;
      for (int a = 0; a < BANK_WORDS; a++) begin
         e = IMPL_MASK[a] & ~HW_MASK[a] & ~W1C_MASK[a];
         go(IO_WRITE_OP, 8'(a), 3'd0, 8'hff);
         check("write done", {7'h00, done}, 8'h01);
         check("strobe", {7'h00, strobe[a] && $countones(strobe) == 1}, 8'h01);
         check("image", byte_at(a), e);
         go(DATA_SPACE_LOAD_OP, 8'(a) + DS_OFFSET, 3'd0, 8'h00);
         check("load", rdata, e);
         go(DATA_SPACE_STORE_OP, 8'(a) + DS_OFFSET, 3'd0, 8'h00);
         go(IO_READ_OP, 8'(a), 3'd0, 8'h00);
         check("read", rdata, 8'h00);
      end
   endtask
   task automatic t_refuse;
      logic [7:0] a;
      for (int o = 0; o < 8; o++) begin
         a = (o >= 6) ? 8'h1f : (o >= 2) ? 8'h20 : 8'h40;
         go(core_op_t'(o), a, 3'd0, 8'h00);
         check("refused", {6'h00, refused, done}, 8'h02);
      end
      go(DATA_SPACE_LOAD_OP, 8'h60, 3'd0, 8'h00);
      check("refused high", {6'h00, refused, done}, 8'h02);
      go(SKIP_IF_IO_BIT_SET_OP, 8'h1f, 3'd0, 8'h00);
      check("bit edge", {6'h00, refused, done}, 8'h01);
      go(IO_READ_OP, 8'h3f, 3'd0, 8'h00);
      check("io edge", {6'h00, refused, done}, 8'h01);
   endtask
   task automatic t_bits;
      logic [7:0] e;
      e = 8'h00;
      for (int b = 0; b < 8; b++) begin
         go(SET_IO_BIT_OP, 8'h14, 3'(b), 8'h00);
         e[b] = 1'b1;
         check("set", byte_at(8'h14), e);
         go(SKIP_IF_IO_BIT_SET_OP, 8'h14, 3'(b), 8'h00);
         check("skip set", {7'h00, skip}, 8'h01);
         go(SKIP_IF_IO_BIT_CLEAR_OP, 8'h14, 3'(b + 1), 8'h00);
         check("skip clear", {7'h00, skip}, {7'h00, b < 7});
      end
      for (int b = 0; b < 8; b += 2) begin
         go(CLEAR_IO_BIT_OP, 8'h14, 3'(b), 8'h00);
         e[b] = 1'b0;
         check("clear", byte_at(8'h14), e);
      end
   endtask
   task automatic t_w1c;
      @(posedge clk);
      evt_req <= '1;
      @(posedge clk);
      evt_req <= '0;
      repeat (2) @(posedge clk);
      check("flags", byte_at(8'h0e), 8'he0);
      go(SET_IO_BIT_OP, 8'h0e, 3'd6, 8'h00);
      check("set flag", byte_at(8'h0e), 8'ha0);
      go(CLEAR_IO_BIT_OP, 8'h0e, 3'd7, 8'h00);
      check("clear flag", byte_at(8'h0e), 8'ha0);
      go(IO_WRITE_OP, 8'h0e, 3'd0, 8'h20);
      check("w1c", byte_at(8'h0e), 8'h80);
      go(IO_WRITE_OP, 8'h0e, 3'd0, 8'h80);
      check("w1c top", byte_at(8'h0e), 8'h00);
      go(IO_WRITE_OP, 8'h0b, 3'd0, 8'h00);
      check("w0 keeps", byte_at(8'h0b), 8'h40);
      go(IO_WRITE_OP, 8'h0b, 3'd0, 8'h40);
      check("w1 clears", byte_at(8'h0b), 8'h00);
      go(SET_IO_BIT_OP, 8'h08, 3'd3, 8'h00);
      check("other flag", byte_at(8'h08), 8'h18);
   endtask
   task automatic t_live;
      @(posedge clk);
      pin_lvl <= 8'ha5;
      lvl_req <= 7'h40;
      repeat (4) @(posedge clk);
      go(IO_READ_OP, 8'h16, 3'd0, 8'h00);
      check("pins b", rdata, 8'ha5);
      go(IO_READ_OP, 8'h10, 3'd0, 8'h00);
      check("pins d", rdata, 8'h25);
      go(DATA_SPACE_LOAD_OP, 8'h28, 3'd0, 8'h00);
      check("level", rdata, 8'h38);
      go(SKIP_IF_IO_BIT_SET_OP, 8'h19, 3'd2, 8'h00);
      check("pin skip", {7'h00, skip}, 8'h01);
   endtask
   task automatic complete_run;
      if (errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      check("reset image", {7'h00, |image}, 8'h00);
      t_map();
      t_refuse();
      t_bits();
      t_w1c();
      t_live();
      complete_run();
   end
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      complete_run();
   end
endmodule
